// ===== include/adc_readout_pkg.sv
// Purpose: Shared constants for the serial converter readout block
// Assumes: 50 MHz system clock, host shift clock well below it
// Notes: Result is unsigned straight binary, 16 bits

package adc_readout_pkg;

  // Result word
  localparam int RESULT_WIDTH = 16;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;

  // Bit counter
  localparam int COUNT_WIDTH = 5;
  localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
  localparam logic [4:0] BITS_PER_WORD = 5'h10;

  // Analog sample word width, one above the result for range detection
  localparam int SAMPLE_WIDTH = 17;

  // Synchroniser reset level: select idles high, shift clock low
  localparam logic [1:0] SELECT_SYNC_RESET = 2'b11;
  localparam logic [1:0] SHIFT_SYNC_RESET = 2'b00;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE = 3'b100
  } conv_state_e;

endpackage : adc_readout_pkg

// ===== hw/result_shifter.sv
// Purpose: Holds one sampled result and presents it one bit at a time
// Assumes: load and shift are single-cycle pulses on clk
// Notes: Most significant bit is presented first; shifted-out bits fill 0

module result_shifter
  import adc_readout_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic load,
  input wire logic shift,
  input wire logic [adc_readout_pkg::RESULT_WIDTH-1:0] load_word,
  // Serial bit
  output logic bit_out
);

  import adc_readout_pkg::*;

  logic [RESULT_WIDTH-1:0] word;

  // Next word: load wins over shift
  wire [RESULT_WIDTH-1:0] next_word = load ? load_word :
    shift ? {word[RESULT_WIDTH-2:0], 1'b0} : word;

  // Word register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      word <= CODE_ZERO;
    else
      word <= next_word;
  end

  // Registered output bit
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_out <= 1'b0;
    else
      bit_out <= next_word[RESULT_WIDTH-1];
  end

endmodule : result_shifter

// ===== hw/adc_readout.sv
// Purpose: Digital side of a 16-bit single-channel sampling converter
// Assumes: Host drives select_n and shift_clock_in, both asynchronous
// Notes: Conversion is modelled as immediate; the analog value arrives
//   as a signed-range sample word and is saturated to 16 bits
//   Both host pins reach logic two clk edges late, and the line
//   enable trails select by three clk edges at either end
//   The host's shift clock must stay well below clk to be seen

module adc_readout
  import adc_readout_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Host select and shift clock
  input wire logic select_n,
  input wire logic shift_clock_in,
  // Serial result line and its enable
  output logic result_out,
  output logic result_oe,
  // Analog front end, signed sample held by the track-and-hold
  input wire logic signed [adc_readout_pkg::SAMPLE_WIDTH-1:0] analog_sample,
  // Status
  output logic converting,
  output logic shutdown
);

  import adc_readout_pkg::*;

  // Sequencer
  conv_state_e state;
  conv_state_e next_state;

  // Host pin synchronisers and their edge history
  logic [1:0] select_sync;
  logic [1:0] shift_sync;
  logic select_prev;
  logic shift_prev;

  // Word progress and the shifter's serial bit
  logic [COUNT_WIDTH-1:0] bit_count;
  logic shifter_bit;

  // Two-stage synchronisers; logic reads stage 1 only
  // Stage 0 may be metastable after a pin edge, so nothing taps it;
  // reset levels match the idle pins, so no false edge follows reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      select_sync <= SELECT_SYNC_RESET;
      shift_sync <= SHIFT_SYNC_RESET;
    end
    else
    begin
      select_sync <= {select_sync[0], select_n};
      shift_sync <= {shift_sync[0], shift_clock_in};
    end
  end

  // Edge history of synchronised inputs
  // History resets to the idle levels: select high, clock low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      select_prev <= 1'b1;
      shift_prev <= 1'b0;
    end
    else
    begin
      select_prev <= select_sync[1];
      shift_prev <= shift_sync[1];
    end
  end

  // High-to-low step of a synchronised level against its history
  // Shared by the select and shift clock decoding
  function automatic logic falling(input logic prev, input logic now);
  begin
    falling = prev & ~now;
  end
  endfunction : falling

  // Edge decode
  wire select_low = ~select_sync[1];
  wire select_fall = falling(select_prev, select_sync[1]);
  wire shift_fall = falling(shift_prev, shift_sync[1]);

  // Sixteenth host clock fall of a word is its last
  wire last_bit = (bit_count == BITS_PER_WORD - 5'h01);

  // Saturating straight-binary coding of the sample word
  // Below zero gives the zero code; the top of the signed range is
  // already the full-scale code, so over-range needs no test of its own
  function automatic logic [RESULT_WIDTH-1:0] to_code(
    input logic signed [SAMPLE_WIDTH-1:0] s);
  begin
    if (s[SAMPLE_WIDTH-1])
      to_code = CODE_ZERO;
    else
      to_code = s[RESULT_WIDTH-1:0];
  end
  endfunction : to_code

  // Code taken straight from the input at the select edge
  // The shifter copies it on that same edge: no pipeline stage
  wire [RESULT_WIDTH-1:0] load_code = to_code(analog_sample);
  wire load_pulse = select_fall;
  wire shift_pulse = (state == ST_SHIFT) & shift_fall & select_low;

  // Word ends on the host clock fall that moves out the last bit
  wire word_done = shift_pulse & last_bit;

  // Sequencer next state
  // A select rise mid-word abandons it; a fresh fall restarts at once
  always_comb
  begin
    next_state = state;
    // Select fall wins in each of the three named states; any other encoding goes to ST_SHUTDOWN
    unique case (state)
      ST_SHUTDOWN:
        if (select_fall)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (select_fall)
          next_state = ST_SHIFT;
        else if (!select_low)
          next_state = ST_SHUTDOWN;
        else if (word_done)
          next_state = ST_DONE;
      ST_DONE:
        next_state = select_fall ? ST_SHIFT : ST_SHUTDOWN;
      default:
        next_state = ST_SHUTDOWN;
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= ST_SHUTDOWN;
    else
      state <= next_state;
  end

  // Bit counter, cleared on each new conversion
  // Only host clock falls inside a word advance it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bit_count <= BIT_COUNT_RESET;
    else if (load_pulse)
      bit_count <= BIT_COUNT_RESET;
    else if (shift_pulse)
      bit_count <= bit_count + 5'h01;
  end

  // Serial result word
  // Loads at the select fall; shifted-out places fill with zero,
  // so host clock falls past the last bit read as 0
  result_shifter u_shifter (
    .clk(clk),
    .rst(rst),
    .load(load_pulse),
    .shift(shift_pulse),
    .load_word(load_code),
    .bit_out(shifter_bit)
  );

  // Output selection; the line rests low whenever it is not driven
  // Status levels are decoded from the coming state
  wire next_result = select_low ? shifter_bit : 1'b0;
  wire next_converting = (next_state == ST_SHIFT);
  wire next_shutdown = (next_state == ST_SHUTDOWN);

  // Line enable follows the synchronised select
  // It trails the pin by the synchroniser depth plus this register, three clk edges, at both ends
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      result_oe <= 1'b0;
    else
      result_oe <= select_low;
  end

  // Serial data from the shifter, gated by the same select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      result_out <= 1'b0;
    else
      result_out <= next_result;
  end

  // Busy level, high while a word is being shifted
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      converting <= 1'b0;
    else
      converting <= next_converting;
  end

  // Shutdown level; set one clk after the last bit (via ST_DONE), straight after an abort
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shutdown <= 1'b1;
    else
      shutdown <= next_shutdown;
  end

endmodule : adc_readout

// ===== test/adc_readout_chk.sv
// Purpose: Port checks for adc_readout
// Assumes: One clk domain
// Notes: Bound below
module adc_readout_chk (
  // Watched ports
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic shift_clock_in,
  input wire logic result_out,
  input wire logic result_oe,
  input wire logic converting,
  input wire logic shutdown
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_oe_on: assert property ($fell(select_n) |-> ##[2:4] result_oe)
    else $error("oe late");
  a_oe_off: assert property (select_n[*4] |-> !result_oe)
    else $error("oe while high");
  a_out_quiet: assert property (!result_oe |-> !result_out)
    else $error("out while off");
  a_conv_start: assert property (
    $fell(select_n) |-> ##[2:5] converting)
    else $error("no start");
  a_to_shutdown: assert property (
    $fell(converting) |-> ##[0:3] shutdown)
    else $error("no shutdown");
  a_idle_down: assert property (select_n[*6] |-> shutdown)
    else $error("idle not down");
  a_one_state: assert property (!(converting && shutdown))
    else $error("two states");
  a_bit_hold: assert property (
    (!select_n && $stable(shift_clock_in))[*6] |-> $stable(result_out))
    else $error("bit moved");
  a_drive_word: assert property (converting |-> result_oe)
    else $error("word not driven");
  // Main scenarios
  c_start: cover property ($rose(result_oe));
  c_done: cover property ($fell(converting) ##[1:3] shutdown);
  c_abort: cover property (converting && select_n);
endmodule : adc_readout_chk

bind adc_readout adc_readout_chk u_adc_readout_chk (.clk(clk), .rst(rst),
  .select_n(select_n), .shift_clock_in(shift_clock_in),
  .result_out(result_out), .result_oe(result_oe),
  .converting(converting), .shutdown(shutdown));

// ===== test/host_model.sv
// Purpose: Host that frames readouts
// Assumes: Shift clock 160 ns, 8 clk
// Notes: Shift clock rests low between frames
module host_model (
  // Clock and serial input
  input wire logic clk,
  input wire logic result_out,
  input wire logic result_oe,
  // Host link
  output logic select_n,
  output logic shift_clock_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    select_n = 1'b1;
    shift_clock_in = 1'b0;
  end
  // Frame of n bits; undriven line reads unknown
  task automatic frame(input int n, output logic [15:0] w);
    w = '0;
    @(posedge clk) select_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk) shift_clock_in <= 1'b1;
      repeat (4) @(posedge clk);
      w = {w[14:0], result_oe ? result_out : 1'bx};
      shift_clock_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    @(posedge clk) select_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : host_model

// ===== test/adc_readout_test.sv
// Purpose: Bench for adc_readout
// Assumes: Host model frames reads
// Notes: Codes, abort, sample hold
module adc_readout_test;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_readout_pkg::*;
  logic clk, rst, select_n, shift_clock_in, result_out, result_oe;
  logic converting, shutdown;
  logic signed [SAMPLE_WIDTH-1:0] analog_sample;
  logic [15:0] w;
  int n_errors, tests_run;
  adc_readout u_adc_readout (.clk(clk), .rst(rst), .select_n(select_n),
    .shift_clock_in(shift_clock_in), .result_out(result_out),
    .result_oe(result_oe), .analog_sample(analog_sample),
    .converting(converting), .shutdown(shutdown));
  host_model u_host_model (.clk(clk), .result_out(result_out),
    .result_oe(result_oe), .select_n(select_n),
    .shift_clock_in(shift_clock_in));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp)
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    if (got !== exp)
      n_errors++;
  endtask : check
  // Sample changes mid-frame; word belongs to the fall
  task automatic t_code(input logic signed [16:0] s);
    logic [15:0] e;
    e = s < 0 ? CODE_ZERO : s[15:0];
    @(posedge clk) analog_sample <= s;
    fork
      u_host_model.frame(16, w);
      begin
        repeat (6) @(posedge clk);
        analog_sample <= ~s;
      end
    join
    check(w, e);
    check({13'h0, result_oe, converting, shutdown}, 16'h0001);
  endtask : t_code
  // Select rises after four bits
  task automatic t_abort();
    @(posedge clk) analog_sample <= 17'sh0_A5C3;
    u_host_model.frame(4, w);
    check(w, 16'h000A);
    check({13'h0, result_oe, converting, shutdown}, 16'h0001);
  endtask : t_abort
  task automatic print_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial
  begin
    rst = 1'b1;
    analog_sample = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({13'h0, result_oe, converting, shutdown}, 16'h0001);
    t_abort();
    t_code(17'sh0_1234);
    t_code(17'sh0_FFFF);
    t_code(17'sh0_0000);
    t_code(17'sh1_FFFF);
    t_code(17'sh1_0000);
    t_code(17'sh0_8001);
    print_verdict();
  end
endmodule : adc_readout_test
